// File: spi_control_status_flags.sv
/*
 * Control register and status flags of the serial peripheral port:
 * transfer complete, write collision, mode fault and receive overrun,
 * with the single port interrupt request.
 * Assumes the shift engine runs on the same system clock and reports its
 * events as one-cycle pulses; the select pin arrives asynchronously.
 */
// Functional notes
// - the transfer-complete flag in bit 7 is set when a transfer ends.
// - with interrupts enabled, the transfer-complete flag raises the irq.
// - a data write during a transfer sets the collision flag in bit 6.
// - the collision flag raises the irq like transfer complete does.
// - select low, master on and mode 01 set the fault flag in bit 5.
// - hardware never clears the flags; software writes them to zero.
// - the overrun flag in bit 4 has meaning only in slave operation.
// - a last bit shifted in while the receive buffer is full sets it.
// - master enable 1 selects master operation, 0 selects slave.
// - mode 01, the default, treats the select pin as an input.
module spi_control_status_flags
   import spi_flags_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   nrst,
   input  wire spi_flags_pkg::sfr_req_t sfr,
   input  wire spi_flags_pkg::shift_evt_t evt,
   input  wire logic                   master_enable,
   input  wire logic                   irq_enable,
   input  wire logic                   select_input,
   output logic [7:0]                  sfr_rdata,
   output logic                        irq,
   output logic                        port_enable,
   output logic [1:0]                  slave_select_mode,
   output logic                        master_mode
);
   import spi_flags_pkg::*;

   logic       transfer_complete_flag_q;
   logic       write_collision_flag_q;
   logic       mode_fault_flag_q;
   logic       receive_overrun_flag_q;
   logic [1:0] ssm_q;
   logic       en_q;
   logic       txe_q;
   logic       select_s;

   // select pin crosses in from outside before any decode looks at it
   pin_sync #(.RESET_LEVEL(1'b1)) u_sel_sync (
      .clock (clock),
      .nrst  (nrst),
      .pin   (select_input),
      .level (select_s)
   );

   // decode of the cpu write and of each flag's set condition
   wire       ctrl_wr   = sfr.wr && (sfr.addr == CTRL_ADDR);
   wire       ctrl_rd   = sfr.rd && (sfr.addr == CTRL_ADDR);
   wire       set_done  = evt.done;
   wire       set_write_collision_flag  = evt.data_write && evt.busy;
   wire       ssm_input = (ssm_q == SSM_4WIRE_IN);
   wire       set_mode_fault_flag  = !select_s && master_enable
                          && ssm_input;
   wire       set_ovrn  = evt.last_bit && evt.rx_full
                          && !master_enable;
   wire       any_flag  = transfer_complete_flag_q | write_collision_flag_q
                        | mode_fault_flag_q | receive_overrun_flag_q;
   wire [7:0] ctrl_view = {transfer_complete_flag_q, write_collision_flag_q,
                           mode_fault_flag_q, receive_overrun_flag_q,
                           ssm_q, txe_q, en_q};

   // software may only write a flag; a set in the same cycle wins
   function automatic logic next_flag(logic cur, logic set, logic wr,
                                      logic wbit);
      next_flag = set ? 1'b1 : (wr ? wbit : cur);
   endfunction

   // flags never clear by themselves, only by a software write of zero
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         transfer_complete_flag_q <= CTRL_RESET[BIT_DONE];
         write_collision_flag_q   <= CTRL_RESET[BIT_WRITE_COLLISION_FLAG];
         mode_fault_flag_q        <= CTRL_RESET[BIT_MODE_FAULT_FLAG];
         receive_overrun_flag_q   <= CTRL_RESET[BIT_OVRN];
      end else begin
         transfer_complete_flag_q <= next_flag(transfer_complete_flag_q,
            set_done, ctrl_wr, sfr.wdata[BIT_DONE]);
         write_collision_flag_q   <= next_flag(write_collision_flag_q,
            set_write_collision_flag, ctrl_wr, sfr.wdata[BIT_WRITE_COLLISION_FLAG]);
         mode_fault_flag_q        <= next_flag(mode_fault_flag_q,
            set_mode_fault_flag, ctrl_wr, sfr.wdata[BIT_MODE_FAULT_FLAG]);
         receive_overrun_flag_q   <= next_flag(receive_overrun_flag_q,
            set_ovrn, ctrl_wr, sfr.wdata[BIT_OVRN]);
      end
   end

   // control fields and the mirrored transmit-empty status
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ssm_q <= CTRL_RESET[BIT_SSM_HI:BIT_SSM_LO];
         en_q  <= CTRL_RESET[BIT_EN];
         txe_q <= CTRL_RESET[BIT_TXE];
      end else begin
         txe_q <= evt.tx_empty;
         if (ctrl_wr) begin
            ssm_q <= sfr.wdata[BIT_SSM_HI:BIT_SSM_LO];
            en_q  <= sfr.wdata[BIT_EN];
         end
      end
   end

   // registered outputs; the irq follows the flags by one cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata         <= 8'h00;
         irq               <= 1'b0;
         port_enable       <= CTRL_RESET[BIT_EN];
         slave_select_mode <= CTRL_RESET[BIT_SSM_HI:BIT_SSM_LO];
         master_mode       <= 1'b0;
      end else begin
         sfr_rdata         <= ctrl_rd ? ctrl_view : 8'h00;
         irq               <= irq_enable && any_flag;
         port_enable       <= en_q;
         slave_select_mode <= ssm_q;
         master_mode       <= master_enable;
      end
   end

   // checks on flag setting, stickiness and the interrupt request
   sequence s_done_seen;
      evt.done;
   endsequence

   sequence s_flag_up;
      ##1 transfer_complete_flag_q;
   endsequence

   chk_done_sets_flag: assert property (
      @(posedge clock) disable iff (!nrst) s_done_seen |-> s_flag_up)
      else $error("transfer complete flag not set after done");

   chk_write_collision_flag_on_busy: assert property (
      @(posedge clock) disable iff (!nrst)
      evt.data_write && evt.busy |=> write_collision_flag_q)
      else $error("collision flag not set on busy write");

   chk_mode_fault_flag_detect: assert property (
      @(posedge clock) disable iff (!nrst)
      !select_s && master_enable && ssm_q == SSM_4WIRE_IN
      |=> mode_fault_flag_q)
      else $error("mode fault not flagged");

   chk_flags_sticky: assert property (
      @(posedge clock) disable iff (!nrst)
      transfer_complete_flag_q && !ctrl_wr |=> transfer_complete_flag_q)
      else $error("transfer complete flag cleared by hardware");

   chk_write_collision_flag_sticky: assert property (
      @(posedge clock) disable iff (!nrst)
      write_collision_flag_q && !ctrl_wr |=> write_collision_flag_q)
      else $error("collision flag cleared by hardware");

   chk_ovrn_slave_only: assert property (
      @(posedge clock) disable iff (!nrst)
      !receive_overrun_flag_q && master_enable && !ctrl_wr
      |=> !receive_overrun_flag_q)
      else $error("overrun set in master operation");

   chk_ovrn_set: assert property (
      @(posedge clock) disable iff (!nrst)
      evt.last_bit && evt.rx_full && !master_enable
      |=> receive_overrun_flag_q)
      else $error("overrun not flagged");

   chk_irq_from_flags: assert property (
      @(posedge clock) disable iff (!nrst)
      irq_enable && any_flag |=> irq)
      else $error("irq missing while a flag is set");

   chk_irq_gated: assert property (
      @(posedge clock) disable iff (!nrst)
      irq |-> $past(irq_enable) && $past(any_flag))
      else $error("irq without enable or flag");

   // further checks: stickiness of the other flags, irq paths, copies
   sequence s_irq_armed;
      evt.done ##1 irq_enable;
   endsequence

   chk_done_irq_path: assert property (
      @(posedge clock) disable iff (!nrst)
      s_irq_armed |=> irq)
      else $error("done did not reach the irq");

   chk_write_collision_flag_raises_irq: assert property (
      @(posedge clock) disable iff (!nrst)
      irq_enable && write_collision_flag_q |=> irq)
      else $error("collision flag did not raise the irq");

   chk_ovrn_irq: assert property (
      @(posedge clock) disable iff (!nrst)
      irq_enable && receive_overrun_flag_q |=> irq)
      else $error("overrun flag did not raise the irq");

   chk_mode_fault_flag_sticky: assert property (
      @(posedge clock) disable iff (!nrst)
      mode_fault_flag_q && !ctrl_wr |=> mode_fault_flag_q)
      else $error("mode fault flag cleared by hardware");

   chk_ovrn_sticky: assert property (
      @(posedge clock) disable iff (!nrst)
      receive_overrun_flag_q && !ctrl_wr |=> receive_overrun_flag_q)
      else $error("overrun flag cleared by hardware");

   // a fault needs the select pin routed as an input
   chk_mode_fault_flag_mode_gate: assert property (
      @(posedge clock) disable iff (!nrst)
      !mode_fault_flag_q && !ssm_input && !ctrl_wr
      |=> !mode_fault_flag_q)
      else $error("mode fault set with the select pin not an input");

   chk_master_copy: assert property (
      @(posedge clock) disable iff (!nrst)
      1'b1 |=> master_mode == $past(master_enable))
      else $error("master mode does not follow master enable");
endmodule

// File: spi_flags_pkg.sv
/*
 * Package for the serial port control and status flag block: register
 * offset, bit positions, reset value, slave-select mode codes and the
 * packed carriers for the special function register access and events.
 * Assumes a byte-wide special function register space on the CPU side.
 */
package spi_flags_pkg;
   localparam logic [7:0] CTRL_ADDR     = 8'hF8; // control register address
   localparam logic [7:0] CTRL_RESET    = 8'h06; // reset value
   localparam int         BIT_DONE      = 7;
   localparam int         BIT_WRITE_COLLISION_FLAG      = 6;
   localparam int         BIT_MODE_FAULT_FLAG      = 5;
   localparam int         BIT_OVRN      = 4;
   localparam int         BIT_SSM_HI    = 3;
   localparam int         BIT_SSM_LO    = 2;
   localparam int         BIT_TXE       = 1;
   localparam int         BIT_EN        = 0;
   localparam logic [1:0] SSM_3WIRE     = 2'h0;
   localparam logic [1:0] SSM_4WIRE_IN  = 2'h1; // select pin is an input
   localparam logic [7:0] FLAG_W_MASK   = 8'hFD; // transmit empty is read only

   // cpu access to the special function register space
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   // events reported by the shift engine on the system clock
   typedef struct packed {
      logic done;       // a byte transfer has finished
      logic busy;       // a transfer is in progress
      logic data_write; // software wrote the data register
      logic last_bit;   // last bit of a byte entered the shift register
      logic rx_full;    // receive buffer still holds unread data
      logic tx_empty;   // transmit buffer empty
   } shift_evt_t;
endpackage

// File: pin_sync.sv
/*
 * Two-stage synchroniser for a single asynchronous pin level.
 * Assumes one system clock and an asynchronous active-low reset.
 */
module pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic pin,
   output logic      level
);
   logic meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_q <= RESET_LEVEL;
         level  <= RESET_LEVEL;
      end else begin
         meta_q <= pin;
         level  <= meta_q;
      end
   end
endmodule

// File: far_side.sv
/*
 * Far side model: an outside master that pulls the select line low
 * while it frames a transfer.
 * Assumes a pull-up on the select line, so it idles high between frames.
 */
module far_side (
   input  wire logic frame,
   output logic      select_input
);
   timeunit 1ns;
   timeprecision 1ns;
   // released line falls back to the pull-up level, never a stale value
   assign select_input = !frame;
endmodule

// File: test_spi_control_status_flags.sv
/*
 * Self-checking bench for the control and status flag block.
 * Assumes the design's own assertions guard timing; bit 1 follows
 * a transmit-empty level that is held at 1 here.
 */
module test_spi_control_status_flags;
   import spi_flags_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clock = 0, nrst = 0, frame = 0, rd_seen = 0;
   logic       master_enable = 0, irq_enable = 0;
   sfr_req_t   sfr = '0;
   shift_evt_t evt = 6'h01;
   logic [7:0] sfr_rdata, exp_q[$];
   logic       irq, port_enable, master_mode, select_input;
   logic [1:0] slave_select_mode;
   int         n_fail = 0, n_compared = 0;
   always #25 clock = ~clock;
   far_side far_side_i (.frame(frame),
      .select_input(select_input));
   spi_control_status_flags spi_control_status_flags_i (.clock(clock),
      .nrst(nrst), .sfr(sfr), .evt(evt), .master_enable(master_enable),
      .irq_enable(irq_enable), .select_input(select_input),
      .sfr_rdata(sfr_rdata), .irq(irq), .port_enable(port_enable),
      .slave_select_mode(slave_select_mode), .master_mode(master_mode));
   task conclude;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task check(input logic ok, input string what);
      n_compared++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   // inputs always move 1 ns after the rising edge
   task cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // one idle edge after each access, so a following call never
   // rewrites sfr in the same time step and register copies settle
   task access(input logic w, input logic [7:0] a, input logic [7:0] d);
      sfr = '{wr: w, rd: !w, addr: a, wdata: d};
      cyc(1);
      sfr = '0;
      cyc(1);
   endtask
   // the expected byte is noted before the read goes out
   task rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      access(1'b0, a, 8'h00);
   endtask
   task pulse(input shift_evt_t e, input int wait_n);
      evt = e;
      cyc(1);
      evt = 6'h01;
      cyc(wait_n);
   endtask
   // read data stands one cycle after the read edge
   always @(posedge clock) begin
      if (rd_seen)
         check(exp_q.size() > 0 && sfr_rdata === exp_q.pop_front(),
            "rd");
      rd_seen <= sfr.rd;
   end
   initial begin
      #100000;
      n_fail++;
      conclude;
   end
   initial begin
      logic [7:0] a;
      void'($urandom(25));
      cyc(2);
      nrst = 1;
      check(slave_select_mode === 2'h1 && !port_enable, "reset");
      rd(CTRL_ADDR, CTRL_RESET);
      irq_enable = 1;
      pulse(6'h21, 2);
      check(irq === 1'b1, "done irq");
      cyc(20);
      rd(CTRL_ADDR, 8'h86);
      access(1'b1, CTRL_ADDR, 8'h06);
      cyc(1);
      check(irq === 1'b0, "irq after clear");
      pulse(6'h09, 1);
      rd(CTRL_ADDR, 8'h06);
      pulse(6'h19, 2);
      check(irq === 1'b1, "collision irq");
      rd(CTRL_ADDR, 8'h46);
      access(1'b1, CTRL_ADDR, 8'h06);
      master_enable = 1;
      pulse(6'h07, 1);
      rd(CTRL_ADDR, 8'h06);
      master_enable = 0;
      pulse(6'h07, 2);
      check(irq === 1'b1, "overrun irq");
      rd(CTRL_ADDR, 8'h16);
      access(1'b1, CTRL_ADDR, 8'h06);
      master_enable = 1;
      frame = 1;
      cyc(5);
      frame = 0;
      cyc(5);
      rd(CTRL_ADDR, 8'h26);
      access(1'b1, CTRL_ADDR, 8'h00);
      frame = 1;
      cyc(5);
      frame = 0;
      rd(CTRL_ADDR, 8'h02);
      access(1'b1, CTRL_ADDR, 8'h07);
      check(port_enable && slave_select_mode === 2'h1 && master_mode,
         "copies");
      irq_enable = 0;
      pulse(6'h21, 3);
      check(irq === 1'b0, "irq gated");
      access(1'b1, CTRL_ADDR, 8'h07);
      // random writes and reads away from the control address
      repeat (4) begin
         a = 8'($urandom);
         if (a == CTRL_ADDR)
            a = 8'hF9;
         access(1'b1, a, 8'($urandom));
         rd(a, 8'h00);
      end
      rd(CTRL_ADDR, 8'h07);
      cyc(3);
      conclude;
   end
endmodule
